//--- verilog/spi_sel_pkg.sv
// shared types and constants of the serial port unit
`default_nettype none
package spi_sel_pkg;

  // ************************************************************
  // select-mode field encodings
  // ************************************************************
  localparam logic [1:0] SEL_THREE_WIRE = 2'h0;
  localparam logic [1:0] SEL_MULTI      = 2'h1;
  localparam int         SEL_HIGH_POS   = 1;
  localparam int         SEL_LOW_POS    = 0;

  // ************************************************************
  // sizes and timing
  // ************************************************************
  localparam int         BYTE_BITS       = 8;
  localparam logic [3:0] BIT_COUNT_FULL  = 4'h8;
  localparam int         SCK_HALF_NS     = 40;
  localparam int         CLK_PERIOD_NS   = 10;
  localparam int         SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // control and flag carriers
  // ************************************************************
  typedef struct packed {
    logic       masterEnable;
    logic       portEnable;
    logic [1:0] selectMode;
  } ctrl_t;

  typedef struct packed {
    logic transferDone;
    logic writeCollision;
    logic modeFault;
    logic overrun;
  } flags_t;

  localparam ctrl_t  CTRL_RESET  = '{masterEnable: 1'b0, portEnable: 1'b0,
                                     selectMode: SEL_MULTI};
  localparam flags_t FLAGS_RESET = '{default: 1'b0};

  // master sequencer, one-hot
  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_LOW  = 3'b010,
    M_HIGH = 3'b100
  } mstate_t;

endpackage
`default_nettype wire

//--- verilog/sync_edge.sv
// two-stage pin synchroniser with edge detection
`default_nettype none
module sync_edge #(
  parameter int W = 4
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // s1 feeds only s2; edges come from s2 against its delayed copy
  always_comb begin
    next_st    = st;
    next_st.s1 = pinIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '{default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign level = st.s2;
  assign rise  = st.s2 & ~st.s3;
  assign fall  = ~st.s2 & st.s3;

endmodule
`default_nettype wire

//--- verilog/spi_master_select_logic.sv
// serial port unit: select logic, master transfers and slave shifting
`default_nettype none
// What this block does
// [R1] bytes shift most significant bit first
// [R2] master drives mosi from shift top bit
// [R3] miso released when disabled or deselected
// [R4] three-wire slave always drives miso
// [R5] four-wire slave ignores sck when deselected
// [R6] mode 00: three-wire, slave always selected
// [R7] mode 01: nss input, selects or faults
// [R8] mode 1x: nss output follows low bit
// [R9] nss pin routed unless mode 00
// [R10] data write loads buffer, starts when empty
// [R11] master shifts mosi while generating sck
// [R12] done flag per transfer, interrupt if enabled
// [R13] slave returns its shift data on miso
// [R14] received byte copied to receive buffer
// [R15] select mode resets to 01
// [R16] nss low in multi-master faults, disables
// [R17] three-wire slave must be only slave
// [R18] bit counter reaches eight, then done
// [R19] write while buffer full collides, dropped
// [R20] flags stay set until software clears
// [R21] mode fault only for enabled master, 01
// [R22] nss output changes only on software write
module spi_master_select_logic
  import spi_sel_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStrobe,
  input  wire logic       rdStrobe,
  output logic      [7:0] rdData,
  input  wire ctrl_t      ctrlIn,
  input  wire logic       ctrlWrite,
  output ctrl_t           ctrlOut,
  input  wire flags_t     flagClear,
  output flags_t          flags,
  input  wire logic       irqEnable,
  output logic            irqRequest,
  output logic            nssRouted,
  input  wire logic       sckIn,
  output logic            sckOut,
  output logic            sckOe,
  input  wire logic       mosiIn,
  output logic            mosiOut,
  output logic            mosiOe,
  input  wire logic       misoIn,
  output logic            misoOut,
  output logic            misoOe,
  input  wire logic       nssIn,
  output logic            nssOut,
  output logic            nssOe
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    ctrl_t      ctrl;
    flags_t     flags;
    mstate_t    mstate;
    logic [7:0] divCnt;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic       shiftFull;
    logic       rxBit;
    logic [7:0] txBuf;
    logic       txFull;
    logic [7:0] rxBuf;
    logic       rxFull;
    logic       sck;
  } state_t;

  state_t st;
  state_t next_st;

  logic [3:0] pinLevel;
  logic [3:0] pinRise;
  logic [3:0] pinFall;

  // every pin input passes two flops before use
  sync_edge #(
    .W (4)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pinIn    ({nssIn, misoIn, mosiIn, sckIn}),
    .level    (pinLevel),
    .rise     (pinRise),
    .fall     (pinFall)
  );

  logic nssLevel;
  logic nssFall;
  logic isMaster;
  logic selected;
  logic sckRise;
  logic sckFall;

  assign nssLevel = pinLevel[3];
  assign nssFall  = pinFall[3];
  assign isMaster = st.ctrl.portEnable & st.ctrl.masterEnable;
  // mode 00 slave is always selected; mode 01 selected by low nss
  assign selected = st.ctrl.portEnable & ~st.ctrl.masterEnable &
                    ((st.ctrl.selectMode == SEL_THREE_WIRE) |         // [R6]
                     (st.ctrl.selectMode == SEL_MULTI & ~nssLevel));  // [R7]
  // deselected slave sees no sck edges at all
  assign sckRise  = selected & pinRise[0];  // [R5]
  assign sckFall  = selected & pinFall[0];  // [R5]

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_st = st;

    // software control write; nss output level follows only this
    if (ctrlWrite) begin
      next_st.ctrl = ctrlIn;  // [R22]
    end

    // software flag clears; hardware sets below win  [R20]
    next_st.flags = st.flags & ~flagClear;

    // receive buffer read frees it
    if (rdStrobe) begin
      next_st.rxFull = 1'b0;
    end

    // data write: dropped and flagged while buffer still full
    if (wrStrobe) begin
      if (st.txFull) begin
        next_st.flags.writeCollision = 1'b1;  // [R19]
      end else begin
        next_st.txBuf  = wrData;  // [R10]
        next_st.txFull = 1'b1;
      end
    end

    // buffered byte moves into an empty shift register
    if (st.txFull & ~st.shiftFull & st.ctrl.portEnable) begin
      next_st.shift     = st.txBuf;  // [R10]
      next_st.shiftFull = 1'b1;
      next_st.txFull    = 1'b0;
      if (isMaster) begin
        next_st.mstate = M_LOW;  // [R11]
        next_st.divCnt = 8'h00;
        next_st.bitCnt = 4'h0;
      end
    end

    // master sequencer: sck low half, then high half per bit
    case (st.mstate)
      M_IDLE: begin
        next_st.sck = 1'b0;
      end
      M_LOW: begin
        next_st.divCnt = st.divCnt + 8'h01;
        if (st.divCnt == 8'(SCK_HALF - 1)) begin
          next_st.divCnt = 8'h00;
          next_st.sck    = 1'b1;  // [R11]
          next_st.rxBit  = pinLevel[2];
          next_st.mstate = M_HIGH;
        end
      end
      M_HIGH: begin
        next_st.divCnt = st.divCnt + 8'h01;
        if (st.divCnt == 8'(SCK_HALF - 1)) begin
          next_st.divCnt = 8'h00;
          next_st.sck    = 1'b0;
          next_st.shift  = {st.shift[6:0], st.rxBit};  // [R1] [R14]
          next_st.bitCnt = st.bitCnt + 4'h1;
          next_st.mstate = M_LOW;
          if (st.bitCnt + 4'h1 == BIT_COUNT_FULL) begin
            // master always delivers the byte
            next_st.bitCnt             = 4'h0;
            next_st.mstate             = M_IDLE;
            next_st.shiftFull          = 1'b0;
            next_st.rxBuf              = {st.shift[6:0], st.rxBit};  // [R14]
            next_st.rxFull             = 1'b1;
            next_st.flags.transferDone = 1'b1;  // [R12] [R18]
          end
        end
      end
      default: begin
        next_st.mstate = M_IDLE;
      end
    endcase

    // slave: sample on rising sck, shift on falling, count bits
    if (sckRise) begin
      next_st.rxBit = pinLevel[1];
    end
    if (sckFall) begin
      next_st.shift  = {st.shift[6:0], st.rxBit};  // [R1] [R13]
      next_st.bitCnt = st.bitCnt + 4'h1;
      if (st.bitCnt + 4'h1 == BIT_COUNT_FULL) begin
        next_st.bitCnt             = 4'h0;  // [R18]
        next_st.shiftFull          = 1'b0;
        next_st.flags.transferDone = 1'b1;  // [R12]
        if (st.rxFull & ~rdStrobe) begin
          next_st.flags.overrun = 1'b1;  // unread byte kept, new one lost
        end else begin
          next_st.rxBuf  = {st.shift[6:0], st.rxBit};
          next_st.rxFull = 1'b1;
        end
      end
    end

    // four-wire slave restarts its byte on a falling nss
    if (~st.ctrl.masterEnable & (st.ctrl.selectMode == SEL_MULTI) & nssFall) begin
      next_st.bitCnt = 4'h0;  // [R7]
    end

    // competing master pulls nss low: give up the bus
    if (isMaster & (st.ctrl.selectMode == SEL_MULTI) & ~nssLevel) begin  // [R21]
      next_st.ctrl.masterEnable = 1'b0;  // [R16]
      next_st.ctrl.portEnable   = 1'b0;
      next_st.flags.modeFault   = 1'b1;  // [R16]
    end

    // disabled port drops any partial byte; only this resets 3-wire count
    if (~next_st.ctrl.portEnable) begin
      next_st.mstate    = M_IDLE;
      next_st.sck       = 1'b0;
      next_st.bitCnt    = 4'h0;
      next_st.divCnt    = 8'h00;
      next_st.shiftFull = 1'b0;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st        <= '0;  // whole vector; enum member gets its code below
      st.ctrl   <= CTRL_RESET;  // [R15]
      st.flags  <= FLAGS_RESET;
      st.mstate <= M_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // outputs and pin drive
  // ************************************************************
  assign rdData     = st.rxBuf;  // [R14]
  assign ctrlOut    = st.ctrl;
  assign flags      = st.flags;
  // flag-level request; masked by software enable
  assign irqRequest = irqEnable & (|st.flags);  // [R12] [R16]
  assign nssRouted  = (st.ctrl.selectMode != SEL_THREE_WIRE);  // [R9]

  assign sckOut  = st.sck;  // [R11]
  assign sckOe   = isMaster;
  assign mosiOut = st.shift[7];  // [R2]
  assign mosiOe  = isMaster;  // [R2]
  assign misoOut = st.shift[7];  // [R4] [R13]
  // released when disabled, master, or deselected four-wire slave
  assign misoOe  = selected;  // [R3] [R4]
  assign nssOut  = st.ctrl.selectMode[SEL_LOW_POS];  // [R8]
  assign nssOe   = st.ctrl.portEnable & st.ctrl.selectMode[SEL_HIGH_POS];  // [R8]

endmodule
`default_nettype wire

//--- sim/spi_sel_properties.sv
// assertion checker for the serial port unit
`default_nettype none
module spi_sel_properties
  import spi_sel_pkg::*;
(
  input wire logic   core_clk,
  input wire logic   rst,
  input wire ctrl_t  ctrlOut,
  input wire flags_t flags,
  input wire flags_t flagClear,
  input wire logic   irqEnable,
  input wire logic   irqRequest,
  input wire logic   nssRouted,
  input wire logic   nssOut,
  input wire logic   nssOe,
  input wire logic   sckOe,
  input wire logic   mosiOe,
  input wire logic   misoOe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // pins, judged once control has settled; nss output level judged whenever driven
  // ****************************************
  a_nss_routed: assert property ($stable(ctrlOut) |-> nssRouted == (ctrlOut.selectMode != 2'h0))
    else $error("nss routing wrong");
  a_nss_level: assert property (nssOe |-> nssOut == ctrlOut.selectMode[0])
    else $error("nss output level wrong");
  a_nss_enable: assert property ($stable(ctrlOut) |-> nssOe == (ctrlOut.portEnable && ctrlOut.selectMode[1]))
    else $error("nss enable wrong");
  a_miso_off: assert property (!ctrlOut.portEnable && $stable(ctrlOut) |-> !misoOe)
    else $error("miso driven while disabled");
  a_miso_three: assert property (ctrlOut == 4'h4 && $stable(ctrlOut) |-> misoOe)
    else $error("three-wire slave miso released");
  a_master_drive: assert property ($stable(ctrlOut) |-> sckOe == (ctrlOut.masterEnable && ctrlOut.portEnable) && mosiOe == sckOe)
    else $error("master pin enable wrong");
  // ****************************************
  // flags and faults
  // ****************************************
  a_irq_any: assert property (irqRequest == (irqEnable && flags != 4'h0))
    else $error("interrupt request wrong");
  a_flags_sticky: assert property (!$past(rst) |-> (($past(flags) & ~$past(flagClear)) & ~flags) == 4'h0)
    else $error("flag dropped without clear");
  a_fault_clears: assert property ($rose(flags.modeFault) |-> !ctrlOut.masterEnable && !ctrlOut.portEnable)
    else $error("fault left port enabled");
  a_fault_master: assert property ($rose(flags.modeFault) |-> $past(ctrlOut.masterEnable) && $past(ctrlOut.selectMode) == SEL_MULTI)
    else $error("fault outside multi-master");
endmodule
bind spi_master_select_logic spi_sel_properties u_props (.core_clk, .rst, .ctrlOut, .flags,
  .flagClear, .irqEnable, .irqRequest, .nssRouted, .nssOut, .nssOe, .sckOe, .mosiOe, .misoOe);
`default_nettype wire

//--- sim/spi_slave_model.sv
// behavioural slave on the far side of the bus
`default_nettype none
module spi_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel,
  input  wire logic       load,
  input  wire logic [7:0] txByte,
  output logic            miso,
  output logic      [7:0] shReg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic smp;
  // preload the byte that goes back to the master
  always @(posedge load) shReg = txByte;
  // sample on rise, shift on fall, msb first, full duplex
  always @(posedge sck) if (sel) smp = mosi;
  always @(negedge sck) if (sel) shReg = {shReg[6:0], smp};
  // sole slave; deselected line shows the inverted top bit of shReg
  assign miso = sel ? shReg[7] : ~shReg[7];
endmodule
`default_nettype wire

//--- sim/tb_spi_master_select_logic.sv
// self-checking bench for the serial port unit
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_spi_master_select_logic import spi_sel_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 0, rst = 1, wrStrobe = 0, ctrlWrite = 0, irqEnable = 0;
  logic       nssDrv = 1, load = 0, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe;
  logic       nssOut, nssOe, irqRequest, nssRouted, slvMiso;
  logic [7:0] wrData = 8'h00, rdData, slvByte = 8'h00, slvSh;
  ctrl_t      ctrlIn = CTRL_RESET, ctrlOut;
  flags_t     flagClear = FLAGS_RESET, flags;
  int         error_cnt = 0, checks = 0;
  logic       rdStrobe = 0, sckDrv = 0, mosiDrv = 0;
  logic [7:0] slvRx;
  // pin levels; the bench plays far master on released sck and mosi, idle low
  wire logic sckPin = sckOe ? sckOut : sckDrv;
  wire logic mosiPin = mosiOe ? mosiOut : mosiDrv;
  wire logic misoPin = misoOe ? misoOut : slvMiso;
  wire logic nssPin = nssOe ? nssOut : nssDrv;
  wire logic slvSel = nssOe ? !nssOut : nssDrv;
  always #5 core_clk = ~core_clk;
  spi_master_select_logic #(.SCK_HALF(4)) DUT (.core_clk, .rst, .wrData, .wrStrobe,
    .rdStrobe, .rdData, .ctrlIn, .ctrlWrite, .ctrlOut, .flagClear, .flags, .irqEnable,
    .irqRequest, .nssRouted, .sckIn(sckPin), .sckOut, .sckOe, .mosiIn(mosiPin), .mosiOut,
    .mosiOe, .misoIn(misoPin), .misoOut, .misoOe, .nssIn(nssPin), .nssOut, .nssOe);
  spi_slave_model u_slave (.sck(sckPin), .mosi(mosiPin), .sel(slvSel), .load,
    .txByte(slvByte), .miso(slvMiso), .shReg(slvSh));
  // ****************************************
  // access tasks
  // ****************************************
  task automatic setCtrl(input logic me, input logic pe, input logic [1:0] md);
    @(posedge core_clk);
    ctrlIn <= '{masterEnable: me, portEnable: pe, selectMode: md};
    ctrlWrite <= 1'b1;
    @(posedge core_clk);
    ctrlWrite <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  // n above one repeats the strobe on the following edges
  task automatic writeBurst(input logic [7:0] b, input int n);
    @(posedge core_clk);
    wrData <= b;
    wrStrobe <= 1'b1;
    repeat (n) @(posedge core_clk);
    wrStrobe <= 1'b0;
  endtask
  task automatic clearFlags();
    @(posedge core_clk);
    flagClear <= 4'hF;
    @(posedge core_clk);
    flagClear <= FLAGS_RESET;
    @(posedge core_clk);
    #1;
  endtask
  task automatic exchange(input logic [7:0] tx, input logic [7:0] back, input int n);
    int k;
    k = 0;
    slvByte = back;
    load = 1'b1;
    #1 load = 1'b0;
    writeBurst(tx, n);
    while (flags.transferDone !== 1'b1 && k < 200) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    #1;
    `CHK(k < 200, 1'b1)
    `CHK(rdData, back)
    `CHK(slvSh, tx)
  endtask
  // bench as far master: sck 4 clocks low, 4 high per bit, msb first
  task automatic masterByte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge core_clk) mosiDrv <= tx[i];
      repeat (3) @(posedge core_clk);
      rx[i] = misoPin;
      sckDrv <= 1'b1;
      repeat (4) @(posedge core_clk);
      sckDrv <= 1'b0;
    end
    // slave finishes three clocks after the last fall
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    #100us;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK(ctrlOut, CTRL_RESET)
    `CHK(nssRouted, 1'b1)
    $display("test reset done");
    setCtrl(1'b1, 1'b1, SEL_THREE_WIRE);
    `CHK(nssRouted, 1'b0)
    exchange(8'hA5, 8'h3C, 2);
    `CHK(flags.writeCollision, 1'b1)
    @(posedge core_clk) irqEnable <= 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    `CHK(irqRequest, 1'b1)
    `CHK(flags.transferDone, 1'b1)
    clearFlags();
    `CHK(flags, FLAGS_RESET)
    $display("test three-wire master done");
    setCtrl(1'b1, 1'b1, 2'h3);
    `CHK(nssOut, 1'b1)
    setCtrl(1'b1, 1'b1, 2'h2);
    `CHK(nssOe, 1'b1)
    exchange(8'hC3, 8'h5A, 1);
    `CHK(nssOut, 1'b0)
    clearFlags();
    $display("test four-wire master done");
    // park nss as an input first; the synchroniser still holds our own low output
    setCtrl(1'b0, 1'b0, SEL_MULTI);
    setCtrl(1'b1, 1'b1, SEL_MULTI);
    `CHK(flags.modeFault, 1'b0)
    @(posedge core_clk) nssDrv <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
    `CHK(flags.modeFault, 1'b1)
    `CHK(ctrlOut.masterEnable | ctrlOut.portEnable, 1'b0)
    clearFlags();
    $display("test mode fault done");
    setCtrl(1'b0, 1'b1, SEL_MULTI);
    `CHK(flags.modeFault, 1'b0)
    `CHK(misoOe, 1'b1)
    // free the receive buffer the master tests left full
    @(posedge core_clk) rdStrobe <= 1'b1;
    @(posedge core_clk) rdStrobe <= 1'b0;
    writeBurst(8'h96, 1);
    masterByte(8'h69, slvRx);
    `CHK(slvRx, 8'h96)
    `CHK(rdData, 8'h69)
    `CHK(flags.transferDone, 1'b1)
    `CHK(flags.overrun, 1'b0)
    // unread byte: the next one is lost and flagged
    masterByte(8'h00, slvRx);
    `CHK(flags.overrun, 1'b1)
    `CHK(rdData, 8'h69)
    @(posedge core_clk) nssDrv <= 1'b1;
    clearFlags();
    `CHK(misoOe, 1'b0)
    masterByte(8'hFF, slvRx);
    `CHK(flags.transferDone, 1'b0)
    setCtrl(1'b0, 1'b1, SEL_THREE_WIRE);
    `CHK(misoOe, 1'b1)
    setCtrl(1'b0, 1'b0, SEL_THREE_WIRE);
    `CHK(misoOe, 1'b0)
    $display("test slave select done");
    report_and_stop();
  end
endmodule
`default_nettype wire
